// >>> shared/stt_pkg.sv
`default_nettype none
package stt_pkg;

  // Register addresses on the parallel port.
  localparam logic [7:0] ADDR_DATA_A = 8'h03;
  localparam logic [7:0] ADDR_DATA_B = 8'h04;
  localparam logic [7:0] ADDR_RX_A   = 8'h05;
  localparam logic [7:0] ADDR_RX_B   = 8'h06;
  localparam logic [7:0] ADDR_TX_A   = 8'h07;
  localparam logic [7:0] ADDR_TX_B   = 8'h08;
  localparam logic [7:0] ADDR_CTRL   = 8'h09;

  // Reset values and the read value of an unmapped address.
  localparam logic [7:0] REG_RESET   = 8'h00;
  localparam logic [7:0] CTRL_RESET  = 8'h00;
  localparam logic [7:0] READ_NONE   = 8'h00;

  // Field positions.
  localparam int IFSEL_BIT     = 7;
  localparam int CTRL_EN_LSB   = 6;
  localparam int CTRL_TYPE_W   = 3;
  localparam int SERIAL_PORTS  = 8;
  localparam int NUM_CHAN      = 2;
  localparam int NUM_IFACE     = 2;

  // Interface select values.
  localparam logic IF_PCM = 1'b0;
  localparam logic IF_SUB = 1'b1;

  // Port and slot layout modes of an address.
  localparam logic [1:0] MODE_0 = 2'h0;
  localparam logic [1:0] MODE_1 = 2'h1;
  localparam logic [1:0] MODE_2 = 2'h2;
  localparam logic [1:0] MODE_3 = 2'h3;

  // Channel type codes.
  localparam logic [2:0] TYPE_NONE   = 3'h0;
  localparam logic [2:0] TYPE_64K    = 3'h1;
  localparam logic [2:0] TYPE_32K_LO = 3'h2;
  localparam logic [2:0] TYPE_32K_HI = 3'h3;
  localparam logic [2:0] TYPE_16K_0  = 3'h4;
  localparam logic [2:0] TYPE_16K_1  = 3'h5;
  localparam logic [2:0] TYPE_16K_2  = 3'h6;
  localparam logic [2:0] TYPE_16K_3  = 3'h7;

  // Bit masks of the time slot bits moved per type.
  localparam logic [7:0] MASK_FULL = 8'hFF;
  localparam logic [7:0] MASK_LO4  = 8'h0F;
  localparam logic [7:0] MASK_HI4  = 8'hF0;
  localparam logic [7:0] MASK_P0   = 8'h03;
  localparam logic [7:0] MASK_P1   = 8'h0C;
  localparam logic [7:0] MASK_P2   = 8'h30;
  localparam logic [7:0] MASK_P3   = 8'hC0;
  localparam logic [7:0] MASK_NONE = 8'h00;

  // Last bit of a slot, counted from the first bit on the line.
  localparam logic [2:0] LAST_BIT  = 3'h7;

  // Received byte handed to the read side.
  typedef struct packed {
    logic       chan;
    logic [7:0] data;
  } stt_rx_word_t;

  // Timing and receive data of one serial highway.
  typedef struct packed {
    logic       frame;
    logic       bit_stb;
    logic [7:0] rxd;
  } stt_hwy_in_t;

  function automatic logic [7:0] type_mask(input logic [2:0] t);
    logic [7:0] m;
    m = MASK_NONE;
    case (t)
      TYPE_64K:    m = MASK_FULL;
      TYPE_32K_LO: m = MASK_LO4;
      TYPE_32K_HI: m = MASK_HI4;
      TYPE_16K_0:  m = MASK_P0;
      TYPE_16K_1:  m = MASK_P1;
      TYPE_16K_2:  m = MASK_P2;
      TYPE_16K_3:  m = MASK_P3;
      default:     m = MASK_NONE;
    endcase
    return m;
  endfunction

endpackage
`default_nettype wire

// >>> hw/stt_slot_decode.sv
`timescale 1ns/1ns
`default_nettype none
module stt_slot_decode (
  // Address field and layout mode.
  input  wire logic [6:0] addr_in,
  input  wire logic [1:0] mode_in,
  // Decoded port and time slot.
  output logic      [2:0] port_out,
  output logic      [6:0] slot_out
);

  // Splits the seven address bits into logical port and time slot.
  always_comb begin
    port_out = 3'h0;
    slot_out = 7'h00;
    unique case (mode_in)
      stt_pkg::MODE_0: begin
        port_out = {1'b0, addr_in[2:1]};
        slot_out = {2'b00, addr_in[6:3], addr_in[0]};
      end
      stt_pkg::MODE_1: begin
        port_out = {2'b00, addr_in[1]};
        slot_out = {1'b0, addr_in[6:3], addr_in[2], addr_in[0]};
      end
      stt_pkg::MODE_2: begin
        port_out = 3'h0;
        slot_out = addr_in;
      end
      stt_pkg::MODE_3: begin
        port_out = addr_in[3:1];
        slot_out = {3'b000, addr_in[6:4], addr_in[0]};
      end
    endcase
  end

endmodule
`default_nettype wire

// >>> hw/stt_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module stt_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  // Clock and reset.
  input  wire logic             clk_sys_in,
  input  wire logic             rstn_in,
  // Fill side.
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  // Drain side.
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr_reg;
  logic [AW:0]      rd_ptr_reg;
  logic             full;
  logic             empty;
  logic             push;
  logic             pop;

  // Pointers carry one wrap bit so full and empty differ.
  assign empty         = (wr_ptr_reg == rd_ptr_reg);
  assign full          = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
                         (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
  assign in_ready_out  = !full;
  assign out_valid_out = !empty;
  assign out_data_out  = mem[rd_ptr_reg[AW-1:0]];
  assign push          = in_valid_in && !full;
  assign pop           = out_ready_in && !empty;

  // Storage array, written on each accepted word.
  always_ff @(posedge clk_sys_in) begin
    if (push) begin
      mem[wr_ptr_reg[AW-1:0]] <= in_data_in;
    end
  end

  // Write and read pointers.
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
    end
  end

  a_fifo_no_overrun: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    full |=> !empty && (wr_ptr_reg == $past(wr_ptr_reg)))
    else $error("FIFO accepted a word while full.");

endmodule
`default_nettype wire

// >>> hw/stt_core.sv
`timescale 1ns/1ns
`default_nettype none
module stt_core (
  // Clock and reset.
  input  wire logic                clk_sys_in,
  input  wire logic                rstn_in,
  // Parallel register port.
  input  wire logic [7:0]          cpu_addr_in,
  input  wire logic                cpu_wr_in,
  input  wire logic                cpu_rd_in,
  input  wire logic [7:0]          cpu_wdata_in,
  output logic      [7:0]          cpu_rdata_out,
  // Layout modes of both highways.
  input  wire logic [1:0]          pcm_mode_in,
  input  wire logic [1:0]          sub_mode_in,
  // Serial highways.
  input  wire stt_pkg::stt_hwy_in_t pcm_in,
  input  wire stt_pkg::stt_hwy_in_t sub_in,
  output logic      [7:0]          pcm_txd_out,
  output logic      [7:0]          pcm_txen_out,
  output logic      [7:0]          sub_txd_out,
  output logic      [7:0]          sub_txen_out,
  // Status.
  output logic                     mem_busy_out
);

  localparam int NC = stt_pkg::NUM_CHAN;
  localparam int NI = stt_pkg::NUM_IFACE;

  stt_pkg::stt_hwy_in_t hwy [NI];
  logic [1:0]           mode [NI];
  logic [2:0]           bit_cnt_reg [NI];
  logic [6:0]           slot_cnt_reg [NI];
  logic [7:0]           ctrl_reg;
  logic [7:0]           rx_addr_reg [NC];
  logic [7:0]           tx_addr_reg [NC];
  logic [7:0]           tx_buf_reg [NC];
  logic [7:0]           rx_buf_reg [NC];
  logic [7:0]           rx_sh_reg [NC];
  logic [7:0]           rx_sh_next [NC];
  logic [7:0]           cap_data [NC];
  logic [7:0]           pend_data_reg [NC];
  logic [NC-1:0]        pend_reg;
  logic [NC-1:0]        cap;
  logic [NC-1:0]        rx_hit;
  logic [NC-1:0]        tx_hit;
  logic [NC-1:0]        tx_on;
  logic [NC-1:0]        tx_val;
  logic [NC-1:0]        tx_if;
  logic [2:0]           tx_port [NC];
  logic [NC-1:0]        accept;
  logic [7:0]           txd_next [NI];
  logic [7:0]           txen_next [NI];
  logic [7:0]           txd_reg [NI];
  logic [7:0]           txen_reg [NI];
  stt_pkg::stt_rx_word_t fifo_in;
  stt_pkg::stt_rx_word_t fifo_out;
  logic                 fifo_in_valid;
  logic                 fifo_in_ready;
  logic                 fifo_out_valid;
  logic                 fifo_out_ready;
  logic                 pop;

  assign hwy[stt_pkg::IF_PCM]  = pcm_in;
  assign hwy[stt_pkg::IF_SUB]  = sub_in;
  assign mode[stt_pkg::IF_PCM] = pcm_mode_in;
  assign mode[stt_pkg::IF_SUB] = sub_mode_in;

  // Bit and slot position of each highway, restarted by its frame pulse.
  for (genvar g = 0; g < NI; g++) begin : g_pos
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
        bit_cnt_reg[g]  <= 3'h0;
        slot_cnt_reg[g] <= 7'h00;
      end else if (hwy[g].frame) begin
        bit_cnt_reg[g]  <= 3'h0;
        slot_cnt_reg[g] <= 7'h00;
      end else if (hwy[g].bit_stb) begin
        bit_cnt_reg[g] <= bit_cnt_reg[g] + 3'h1;
        if (bit_cnt_reg[g] == stt_pkg::LAST_BIT) begin
          slot_cnt_reg[g] <= slot_cnt_reg[g] + 7'h01;
        end
      end
    end

    a_frame_restart: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      hwy[g].frame |=> (bit_cnt_reg[g] == 3'h0) && (slot_cnt_reg[g] == 7'h00))
      else $error("Frame pulse did not restart the slot position.");
  end

  // Control register: enables and channel types.
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ctrl_reg <= stt_pkg::CTRL_RESET;
    end else if (cpu_wr_in && cpu_addr_in == stt_pkg::ADDR_CTRL) begin
      ctrl_reg <= cpu_wdata_in;
    end
  end

  // Per channel: addresses, buffers, receive capture and transmit select.
  for (genvar c = 0; c < NC; c++) begin : g_chan
    localparam logic [7:0] A_DATA = (c == 0) ? stt_pkg::ADDR_DATA_A : stt_pkg::ADDR_DATA_B;
    localparam logic [7:0] A_RX   = (c == 0) ? stt_pkg::ADDR_RX_A : stt_pkg::ADDR_RX_B;
    localparam logic [7:0] A_TX   = (c == 0) ? stt_pkg::ADDR_TX_A : stt_pkg::ADDR_TX_B;
    logic       en;
    logic [2:0] typ;
    logic       rx_if;
    logic [2:0] rx_port;
    logic [6:0] rx_slot;
    logic [6:0] tx_slot;
    logic [7:0] rx_mask;
    logic [7:0] tx_mask;
    logic [2:0] rx_pos;
    logic [2:0] tx_pos;
    logic       rx_stb;

    assign en    = ctrl_reg[stt_pkg::CTRL_EN_LSB + c];
    assign typ   = ctrl_reg[stt_pkg::CTRL_TYPE_W * c +: stt_pkg::CTRL_TYPE_W];
    assign rx_if = rx_addr_reg[c][stt_pkg::IFSEL_BIT];
    assign tx_if[c] = tx_addr_reg[c][stt_pkg::IFSEL_BIT];

    // Receive and transmit addresses share the port and slot split.
    stt_slot_decode u_rx_dec (
      .addr_in  (rx_addr_reg[c][6:0]),
      .mode_in  (mode[rx_if]),
      .port_out (rx_port),
      .slot_out (rx_slot)
    );
    stt_slot_decode u_tx_dec (
      .addr_in  (tx_addr_reg[c][6:0]),
      .mode_in  (mode[tx_if[c]]),
      .port_out (tx_port[c]),
      .slot_out (tx_slot)
    );

    // Subscriber slots always move the whole byte.
    assign rx_mask = (rx_if == stt_pkg::IF_SUB) ? stt_pkg::MASK_FULL
                                                : stt_pkg::type_mask(typ);
    assign tx_mask = (tx_if[c] == stt_pkg::IF_SUB) ? stt_pkg::MASK_FULL
                                                 : stt_pkg::type_mask(typ);
    // The first bit on the line is buffer bit 7.
    assign rx_pos  = ~bit_cnt_reg[rx_if];
    assign tx_pos  = ~bit_cnt_reg[tx_if[c]];

    // A pending capture stalls further capture until the FIFO takes it.
    assign rx_hit[c] = en && !pend_reg[c] && (slot_cnt_reg[rx_if] == rx_slot);
    assign rx_stb    = rx_hit[c] && hwy[rx_if].bit_stb && !hwy[rx_if].frame;
    assign cap[c]    = rx_stb && (bit_cnt_reg[rx_if] == stt_pkg::LAST_BIT);
    assign tx_hit[c] = en && (slot_cnt_reg[tx_if[c]] == tx_slot);
    assign tx_on[c]  = tx_hit[c] && tx_mask[tx_pos];
    assign tx_val[c] = tx_buf_reg[c][tx_pos];

    // Shift register of the bit taken in this cycle.
    always_comb begin
      rx_sh_next[c] = rx_sh_reg[c];
      if (rx_stb && rx_mask[rx_pos]) begin
        rx_sh_next[c][rx_pos] = hwy[rx_if].rxd[rx_port];
      end
    end
    // Bits outside the sub-slot keep their previous received value.
    assign cap_data[c] = (rx_buf_reg[c] & ~rx_mask) | (rx_sh_next[c] & rx_mask);

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
        rx_sh_reg[c] <= stt_pkg::REG_RESET;
      end else begin
        rx_sh_reg[c] <= rx_sh_next[c];
      end
    end

    // Completed slot waits here until the FIFO accepts it.
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
        pend_reg[c]      <= 1'b0;
        pend_data_reg[c] <= stt_pkg::REG_RESET;
      end else if (cap[c]) begin
        pend_reg[c]      <= 1'b1;
        pend_data_reg[c] <= cap_data[c];
      end else if (accept[c]) begin
        pend_reg[c] <= 1'b0;
      end
    end

    // Software registers of the channel; a data write fills only the transmit byte.
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
        rx_addr_reg[c] <= stt_pkg::REG_RESET;
        tx_addr_reg[c] <= stt_pkg::REG_RESET;
        tx_buf_reg[c]  <= stt_pkg::REG_RESET;
      end else if (cpu_wr_in) begin
        if (cpu_addr_in == A_RX) begin
          rx_addr_reg[c] <= cpu_wdata_in;
        end
        if (cpu_addr_in == A_TX) begin
          tx_addr_reg[c] <= cpu_wdata_in;
        end
        if (cpu_addr_in == A_DATA) begin
          tx_buf_reg[c] <= cpu_wdata_in;
        end
      end
    end

    a_capture_held: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      cap[c] |=> pend_reg[c] && (pend_data_reg[c] == $past(cap_data[c])))
      else $error("Completed slot was not held for the FIFO.");

    a_type_zero_idle: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      (typ == stt_pkg::TYPE_NONE && tx_if[c] == stt_pkg::IF_PCM) |-> !tx_on[c])
      else $error("Channel with type zero drove a PCM bit.");

    a_write_separate: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      (cpu_wr_in && cpu_addr_in == A_DATA && !pop)
      |=> (tx_buf_reg[c] == $past(cpu_wdata_in)) && (rx_buf_reg[c] == $past(rx_buf_reg[c])))
      else $error("Data write disturbed the received byte.");
  end

  // Channel A takes the FIFO first when both have a byte waiting.
  assign fifo_in_valid = |pend_reg;
  assign fifo_in.chan  = !pend_reg[0];
  assign fifo_in.data  = pend_reg[0] ? pend_data_reg[0] : pend_data_reg[1];
  assign accept[0]     = fifo_in_ready && pend_reg[0];
  assign accept[1]     = fifo_in_ready && pend_reg[1] && !pend_reg[0];

  stt_fifo #(
    .WIDTH ($bits(stt_pkg::stt_rx_word_t)),
    .DEPTH (16)
  ) u_rx_fifo (
    .clk_sys_in    (clk_sys_in),
    .rstn_in       (rstn_in),
    .in_valid_in   (fifo_in_valid),
    .in_ready_out  (fifo_in_ready),
    .in_data_in    (fifo_in),
    .out_valid_out (fifo_out_valid),
    .out_ready_in  (fifo_out_ready),
    .out_data_out  (fifo_out)
  );

  // A register read stalls the drain so the byte cannot change under it.
  assign fifo_out_ready = !cpu_rd_in;
  assign pop            = fifo_out_valid && fifo_out_ready;

  // Received bytes become readable in their channel's data buffer.
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rx_buf_reg[0] <= stt_pkg::REG_RESET;
      rx_buf_reg[1] <= stt_pkg::REG_RESET;
    end else if (pop) begin
      rx_buf_reg[fifo_out.chan] <= fifo_out.data;
    end
  end

  // Transmit bit of every port; channel A wins a shared port and slot.
  always_comb begin
    for (int g = 0; g < NI; g++) begin
      txd_next[g]  = 8'h00;
      txen_next[g] = 8'h00;
    end
    for (int c = NC - 1; c >= 0; c--) begin
      if (tx_on[c]) begin
        txd_next[tx_if[c]][tx_port[c]]  = tx_val[c];
        txen_next[tx_if[c]][tx_port[c]] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      for (int g = 0; g < NI; g++) begin
        txd_reg[g]  <= 8'h00;
        txen_reg[g] <= 8'h00;
      end
    end else begin
      for (int g = 0; g < NI; g++) begin
        txd_reg[g]  <= txd_next[g];
        txen_reg[g] <= txen_next[g];
      end
    end
  end

  assign pcm_txd_out  = txd_reg[stt_pkg::IF_PCM];
  assign pcm_txen_out = txen_reg[stt_pkg::IF_PCM];
  assign sub_txd_out  = txd_reg[stt_pkg::IF_SUB];
  assign sub_txen_out = txen_reg[stt_pkg::IF_SUB];

  // Busy while a selected slot is on the line or a byte is in flight.
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      mem_busy_out <= 1'b0;
    end else begin
      mem_busy_out <= (|rx_hit) || (|tx_hit) || (|pend_reg) || fifo_out_valid;
    end
  end

  // Register read data, captured on the read strobe.
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cpu_rdata_out <= stt_pkg::READ_NONE;
    end else if (cpu_rd_in) begin
      case (cpu_addr_in)
        stt_pkg::ADDR_DATA_A: cpu_rdata_out <= rx_buf_reg[0];
        stt_pkg::ADDR_DATA_B: cpu_rdata_out <= rx_buf_reg[1];
        stt_pkg::ADDR_RX_A:   cpu_rdata_out <= rx_addr_reg[0];
        stt_pkg::ADDR_RX_B:   cpu_rdata_out <= rx_addr_reg[1];
        stt_pkg::ADDR_TX_A:   cpu_rdata_out <= tx_addr_reg[0];
        stt_pkg::ADDR_TX_B:   cpu_rdata_out <= tx_addr_reg[1];
        stt_pkg::ADDR_CTRL:   cpu_rdata_out <= ctrl_reg;
        default:              cpu_rdata_out <= stt_pkg::READ_NONE;
      endcase
    end
  end

  a_disabled_quiet: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (ctrl_reg[7:6] == 2'b00) [*2] |-> (txen_reg[0] == 8'h00) && (txen_reg[1] == 8'h00))
    else $error("Disabled channels drove a highway.");

  a_tx_a_drive: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    tx_on[0] |=> txen_reg[$past(tx_if[0])][$past(tx_port[0])]
             && (txd_reg[$past(tx_if[0])][$past(tx_port[0])] == $past(tx_val[0])))
    else $error("Channel A bit not driven on its slot.");

  a_busy_pending: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (pend_reg != 2'b00) |=> mem_busy_out)
    else $error("Busy flag low while a transfer was pending.");

  a_drain_buffer: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    pop |=> rx_buf_reg[$past(fifo_out.chan)] == $past(fifo_out.data))
    else $error("Drained byte did not reach its data buffer.");

  a_decode_mode3: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (mode[tx_if[1]] == stt_pkg::MODE_3) |-> (tx_port[1] == tx_addr_reg[1][3:1]))
    else $error("Mode 3 port field decoded wrongly.");

  a_read_ctrl: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (cpu_rd_in && cpu_addr_in == stt_pkg::ADDR_CTRL) |=> cpu_rdata_out == $past(ctrl_reg))
    else $error("Control register read returned the wrong value.");

endmodule
`default_nettype wire

// >>> tb/stt_hwy_model.sv
`timescale 1ns/1ns
`default_nettype none
module stt_hwy_model #(
  parameter int SLOTS = 8
) (
  // Clock and reset.
  input  wire logic           clk_sys_in,
  input  wire logic           rstn_in,
  // Pattern salt, watched port and device drive.
  input  wire logic [7:0]     salt_in,
  input  wire logic [2:0]     cap_port_in,
  input  wire logic [7:0]     txd_in,
  input  wire logic [7:0]     txen_in,
  // Highway timing, receive lines and captured transmit result.
  output var stt_pkg::stt_hwy_in_t hwy_out,
  output logic      [7:0]     cap_byte_out,
  output logic      [7:0]     cap_count_out
);
  int         cnt;
  logic [7:0] sh;
  logic [7:0] nb;
  logic [7:0] n;

  // Four clocks a bit; slot s of port p carries {s,p} xor salt, first bit is bit 7.
  always_comb begin
    hwy_out.frame = cnt == 0;
    hwy_out.bit_stb = cnt % 4 == 3;
    for (int p = 0; p < 8; p++) begin
      n = 8'((cnt / 32) * 16 + p) ^ salt_in;
      hwy_out.rxd[p] = n[7 - (cnt / 4) % 8];
    end
  end

  // Frame counter; driven bits of the watched port are shifted in and latched per frame.
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cnt <= 0;
      sh <= 8'h00;
      nb <= 8'h00;
      cap_byte_out <= 8'h00;
      cap_count_out <= 8'h00;
    end else if (cnt == SLOTS * 32 - 1) begin
      cnt <= 0;
      cap_byte_out <= sh;
      cap_count_out <= nb;
      nb <= 8'h00;
    end else begin
      cnt <= cnt + 1;
      if (hwy_out.bit_stb && txen_in[cap_port_in]) begin
        sh <= {sh[6:0], txd_in[cap_port_in]};
        nb <= nb + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// >>> tb/sync_timeslot_transfer_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module sync_timeslot_transfer_tb_top;
  logic       clk_sys_in, rstn_in, wr, rd, busy;
  logic [7:0] addr, wdata, rdata, ptxd, ptxen, stxd, stxen;
  logic [7:0] pcap, pcnt, scap, scnt, psalt, ssalt, got, prev, v;
  logic [1:0] smode;
  stt_pkg::stt_hwy_in_t phwy, shwy;
  int         fail_count, checks_done, busy_seen;
  // Reference masks per type code, sub addresses per mode and their expected bytes.
  logic [7:0] masks [8] = '{8'h00, 8'hFF, 8'h0F, 8'hF0, 8'h03, 8'h0C, 8'h30, 8'hC0};
  logic [7:0] adrs [4] = '{8'h8D, 8'h87, 8'h83, 8'h95};
  logic [7:0] exb [4] = '{8'h32, 8'h31, 8'h30, 8'h32};

  stt_core uut (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .cpu_addr_in(addr),
    .cpu_wr_in(wr), .cpu_rd_in(rd), .cpu_wdata_in(wdata), .cpu_rdata_out(rdata),
    .pcm_mode_in(2'h2), .sub_mode_in(smode), .pcm_in(phwy), .sub_in(shwy),
    .pcm_txd_out(ptxd), .pcm_txen_out(ptxen), .sub_txd_out(stxd),
    .sub_txen_out(stxen), .mem_busy_out(busy));
  stt_hwy_model pcm_m (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .salt_in(psalt),
    .cap_port_in(3'h0), .txd_in(ptxd), .txen_in(ptxen), .hwy_out(phwy),
    .cap_byte_out(pcap), .cap_count_out(pcnt));
  stt_hwy_model sub_m (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .salt_in(ssalt),
    .cap_port_in(3'h2), .txd_in(stxd), .txen_in(stxen), .hwy_out(shwy),
    .cap_byte_out(scap), .cap_count_out(scnt));

  // Free-running system clock.
  initial begin
    clk_sys_in = 1'b0;
    forever #4 clk_sys_in = ~clk_sys_in;
  end

  // Prints the verdict and ends the run.
  task automatic complete_run();
    if (fail_count == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Compares one byte result.
  task automatic check8(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // One-cycle write and read strobes on the register port.
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys_in);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys_in);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  // Waits for n frame starts, each bounded, counting busy cycles meanwhile.
  task automatic frames(input int n);
    int k;
    busy_seen = 0;
    repeat (n) begin
      k = 0;
      do begin
        @(posedge clk_sys_in);
        #1 k++;
        busy_seen += int'(busy !== 1'b0);
      end while (!phwy.frame && k < 300);
      if (k >= 300) begin
        fail_count++;
        complete_run();
      end
    end
  endtask

  // Main sequence.
  initial begin
    rstn_in = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    smode = 2'h0;
    psalt = 8'h00;
    ssalt = 8'h00;
    prev = 8'h00;
    fail_count = 0;
    checks_done = 0;
    void'($urandom(32'h507d));
    repeat (16) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    // Registers clear after reset; the unmapped address reads zero.
    for (int a = 3; a < 11; a++) begin
      rreg(8'(a), got);
      check8(got, 8'h00);
    end
    // Address registers keep what is written.
    for (int a = 5; a < 9; a++) begin
      v = 8'($urandom);
      wreg(8'(a), v);
      rreg(8'(a), got);
      check8(got, v);
    end
    wreg(stt_pkg::ADDR_RX_A, 8'h02);
    wreg(stt_pkg::ADDR_TX_A, 8'h01);
    wreg(stt_pkg::ADDR_TX_B, 8'h8D);
    // Every nonzero type on a PCM slot; the sub slot walks the layout modes at full rate.
    for (int t = 1; t < 8; t++) begin
      frames(1);
      wreg(stt_pkg::ADDR_CTRL, {2'b11, 3'h1, 3'(t)});
      wreg(stt_pkg::ADDR_RX_B, adrs[t % 4]);
      smode <= 2'(t % 4);
      psalt <= 8'($urandom);
      ssalt <= 8'($urandom);
      frames(3);
      prev = (prev & ~masks[t]) | ((8'h20 ^ psalt) & masks[t]);
      rreg(stt_pkg::ADDR_DATA_A, got);
      check8(got, prev);
      rreg(stt_pkg::ADDR_DATA_B, got);
      check8(got, exb[t % 4] ^ ssalt);
      check8(8'(busy_seen != 0), 8'h01);
      check8(pcnt, 8'($countones(masks[t])));
    end
    // Both buffers go out once a frame; the received byte stays apart.
    wreg(stt_pkg::ADDR_CTRL, 8'hC9);
    smode <= 2'h0;
    v = 8'($urandom);
    wreg(stt_pkg::ADDR_DATA_A, v);
    wreg(stt_pkg::ADDR_DATA_B, ~v);
    frames(3);
    check8(pcap, v);
    check8(scap, ~v);
    check8(pcnt, 8'h08);
    check8(scnt, 8'h08);
    rreg(stt_pkg::ADDR_DATA_A, got);
    check8(got, 8'h20 ^ psalt);
    // Back-to-back reads stall the drain until the FIFO fills; captures resume afterwards.
    addr <= stt_pkg::ADDR_CTRL;
    rd <= 1'b1;
    frames(9);
    rd <= 1'b0;
    check8(rdata, 8'hC9);
    frames(1);
    rreg(stt_pkg::ADDR_DATA_A, got);
    check8(got, 8'h20 ^ psalt);
    // Type zero on a PCM slot moves no bit; channel B stays off.
    wreg(stt_pkg::ADDR_CTRL, 8'h48);
    frames(2);
    check8(pcnt, 8'h00);
    check8(scnt, 8'h00);
    rreg(stt_pkg::ADDR_DATA_A, got);
    check8(got, 8'h20 ^ psalt);
    // Disabled channels neither drive nor hold the busy flag.
    wreg(stt_pkg::ADDR_CTRL, 8'h09);
    frames(2);
    check8(pcnt + scnt, 8'h00);
    frames(1);
    check8(8'(busy_seen), 8'h00);
    complete_run();
  end
endmodule
`default_nettype wire
